// >>> include/ipf_pkg.sv
// constants, types and helpers of the interrupt priority and flag block
//
// Overview of operation
// - a source flag sets when its peripheral is enabled and its event occurs.
// - flags set regardless of the interrupt enable, so software may poll them.
// - a set flag stays set until software clears it.
// - priority level is 3 bits; 1 to 7 are levels, 0 keeps the source out of arbitration.
// - subpriority is 2 bits giving subpriority 0 to 3.
// - slot 3 priority sits at bits 28-26, subpriority at bits 25-24.
// - slot 2 at bits 20-18 and 17-16; lower slots repeat in lower bytes.
// - top three bits of every priority byte ignore writes and read zero.
// - sixty-four priority registers, each holding four source slots.
// - clear, set and invert aliases sit at offsets 0x4, 0x8 and 0xC.
`default_nettype none

package ipf_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_SRC       = 256;
    localparam int NUM_PRIO_REGS = 64;
    localparam int NUM_WORDS     = 8;
    localparam int ADDR_W        = 12;
    localparam int SRC_W         = 8;

    // ------------------------------------------------------------
    // register map: index = byte address / 16, alias in bits 3:2
    // ------------------------------------------------------------
    localparam logic [7:0] FLAG_IDX       = 8'h00;
    localparam logic [7:0] ENABLE_IDX     = 8'h08;
    localparam logic [7:0] PRIO_IDX       = 8'h10;
    localparam logic [7:0] IRQ_STATUS_IDX = 8'h50;
    localparam logic [7:0] IRQ_MASK_IDX   = 8'h51;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int          SLOT_W     = 8;
    localparam int          PRIO_LSB   = 2;
    localparam int          SUB_LSB    = 0;
    localparam logic [31:0] FIELD_MASK = 32'h1F1F_1F1F;
    localparam logic [2:0]  PRIO_RST   = 3'h0;
    localparam logic [1:0]  SUB_RST    = 2'h0;
    localparam logic [31:0] REG_RST    = 32'h0000_0000;

    // alias of a register: base, +0x4 clear, +0x8 set, +0xC invert
    typedef enum logic [1:0] {OP_WRITE, OP_CLR, OP_SET, OP_INV} ipf_op_e;

    function automatic logic [31:0] ipf_apply(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input ipf_op_e     op);
        logic [31:0] res;
        res = old;
        unique case (op)
            OP_WRITE: res = wd;
            OP_CLR:   res = old & ~wd;
            OP_SET:   res = old | wd;
            OP_INV:   res = old ^ wd;
        endcase
        return res;
    endfunction : ipf_apply

endpackage : ipf_pkg

`default_nettype wire

// >>> rtl/ipf_top.sv
// interrupt flags, enables, per-source priority bank and request arbiter
//
// Design decisions made here: the register addresses and strobed register access.
`default_nettype none

module ipf_top (
    // clock and reset
    input  wire logic                         ref_clk_in,
    input  wire logic                         sys_rst_in,
    // register port
    input  wire logic [ipf_pkg::ADDR_W-1:0]   addr_in,
    input  wire logic [31:0]                  wr_data_in,
    input  wire logic                         wr_strobe_in,
    input  wire logic                         rd_strobe_in,
    output logic      [31:0]                  rd_data_out,
    // peripheral sources
    input  wire logic [ipf_pkg::NUM_SRC-1:0]  src_event_in,
    input  wire logic [ipf_pkg::NUM_SRC-1:0]  src_periph_en_in,
    // request to the core
    output logic                              req_valid_out,
    output logic      [ipf_pkg::SRC_W-1:0]    req_source_out,
    output logic      [2:0]                   req_priority_out,
    output logic      [1:0]                   req_subpriority_out,
    output logic                              irq_out
);
    import ipf_pkg::*;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic [7:0]   reg_idx = addr_in[ADDR_W-1:4];
    wire ipf_op_e      op      = ipf_op_e'(addr_in[3:2]);
    wire logic         flag_hit  = reg_idx[7:3] == FLAG_IDX[7:3];
    wire logic         en_hit    = reg_idx[7:3] == ENABLE_IDX[7:3];
    wire logic [7:0]   prio_off  = reg_idx - PRIO_IDX;
    wire logic         prio_hit  = (reg_idx >= PRIO_IDX) && (prio_off < 8'(NUM_PRIO_REGS));
    wire logic         st_hit    = reg_idx == IRQ_STATUS_IDX;
    wire logic         mask_hit  = reg_idx == IRQ_MASK_IDX;

    logic [31:0]          flag_word   [NUM_WORDS];
    logic [31:0]          enable_word [NUM_WORDS];
    logic [2:0]           slot_priority_level [NUM_SRC];
    logic [1:0]           slot_subpriority    [NUM_SRC];
    logic [31:0]          prio_word   [NUM_PRIO_REGS];
    logic [NUM_SRC-1:0]   flags;
    logic [NUM_SRC-1:0]   enables;
    logic [NUM_SRC-1:0]   raise;
    logic                 irq_status;
    logic                 irq_mask;

    assign raise = src_event_in & src_periph_en_in;

    // ------------------------------------------------------------
    // flag and enable words
    // ------------------------------------------------------------
    genvar w;
    generate
        for (w = 0; w < NUM_WORDS; w++) begin : g_word
            wire logic        f_wr = wr_strobe_in && flag_hit && reg_idx[2:0] == 3'(w);
            wire logic        e_wr = wr_strobe_in && en_hit && reg_idx[2:0] == 3'(w);
            wire logic [31:0] f_kept = f_wr ? ipf_apply(flag_word[w], wr_data_in, op)
                                            : flag_word[w];
            // an event in the clearing cycle is kept: the set wins
            wire logic [31:0] next_flag = f_kept | raise[w*32 +: 32];
            wire logic [31:0] next_en   = e_wr ? ipf_apply(enable_word[w], wr_data_in, op)
                                               : enable_word[w];
            always_ff @(posedge ref_clk_in) begin
                if (sys_rst_in) begin
                    flag_word[w]   <= REG_RST;
                    enable_word[w] <= REG_RST;
                end else begin
                    flag_word[w]   <= next_flag;
                    enable_word[w] <= next_en;
                end
            end
            assign flags[w*32 +: 32]   = flag_word[w];
            assign enables[w*32 +: 32] = enable_word[w];
        end
    endgenerate

    // ------------------------------------------------------------
    // priority control bank
    // ------------------------------------------------------------
    genvar r, s;
    generate
        for (r = 0; r < NUM_PRIO_REGS; r++) begin : g_prio
            wire logic        p_wr = wr_strobe_in && prio_hit && prio_off == 8'(r);
            // reserved bits are masked out, so they never store
            wire logic [31:0] next_word =
                ipf_apply(prio_word[r], wr_data_in, op) & FIELD_MASK;
            for (s = 0; s < 4; s++) begin : g_slot
                assign prio_word[r][s*SLOT_W +: SLOT_W] = {3'h0,
                    slot_priority_level[r*4+s], slot_subpriority[r*4+s]};
                always_ff @(posedge ref_clk_in) begin
                    if (sys_rst_in) begin
                        slot_priority_level[r*4+s] <= PRIO_RST;
                        slot_subpriority[r*4+s]    <= SUB_RST;
                    end else if (p_wr) begin
                        slot_priority_level[r*4+s] <=
                            next_word[s*SLOT_W+PRIO_LSB +: 3];
                        slot_subpriority[r*4+s]    <=
                            next_word[s*SLOT_W+SUB_LSB +: 2];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // arbiter
    // ------------------------------------------------------------
    logic             win_valid;
    logic [SRC_W-1:0] win_idx;
    logic [4:0]       win_key;

    // linear scan: lowest index wins ties; long chain traded for small area
    always_comb begin
        win_valid = 1'b0;
        win_idx   = '0;
        win_key   = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (flags[i] && enables[i] && slot_priority_level[i] != 3'h0 &&
                (!win_valid ||
                 {slot_priority_level[i], slot_subpriority[i]} > win_key)) begin
                win_valid = 1'b1;
                win_idx   = SRC_W'(i);
                win_key   = {slot_priority_level[i], slot_subpriority[i]};
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt status, mask and read port
    // ------------------------------------------------------------
    wire logic new_flag   = |(raise & ~flags);
    wire logic st_clr     = wr_strobe_in && st_hit && wr_data_in[0];
    wire logic next_stat  = (irq_status && !st_clr) || new_flag;
    wire logic next_mask  = (wr_strobe_in && mask_hit) ? wr_data_in[0] : irq_mask;

    logic [31:0] next_rd;
    always_comb begin
        next_rd = REG_RST;
        if (rd_strobe_in) begin
            if (flag_hit)
                next_rd = flag_word[reg_idx[2:0]];
            else if (en_hit)
                next_rd = enable_word[reg_idx[2:0]];
            else if (prio_hit)
                next_rd = prio_word[prio_off[5:0]];
            else if (st_hit)
                next_rd = {31'h0, irq_status};
            else if (mask_hit)
                next_rd = {31'h0, irq_mask};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            irq_status          <= 1'b0;
            irq_mask            <= 1'b0;
            rd_data_out         <= REG_RST;
            req_valid_out       <= 1'b0;
            req_source_out      <= '0;
            req_priority_out    <= PRIO_RST;
            req_subpriority_out <= SUB_RST;
        end else begin
            irq_status          <= next_stat;
            irq_mask            <= next_mask;
            rd_data_out         <= next_rd;
            req_valid_out       <= win_valid;
            req_source_out      <= win_idx;
            req_priority_out    <= win_key[4:2];
            req_subpriority_out <= win_key[1:0];
        end
    end

    assign irq_out = irq_status && irq_mask;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PRIO0_ADDR  = {PRIO_IDX, 4'h0};
    localparam logic [ADDR_W-1:0] PRIO63_ADDR = {PRIO_IDX + 8'd63, 4'h0};
    localparam logic [ADDR_W-1:0] FSET_ADDR   = {FLAG_IDX, 4'h8};

    logic rd_prio_q;
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in)
            rd_prio_q <= 1'b0;
        else
            rd_prio_q <= rd_strobe_in && prio_hit;
    end

    wire logic clr4 = wr_strobe_in && flag_hit && reg_idx[2:0] == 3'h0 &&
                      ((op == OP_WRITE && !wr_data_in[4]) ||
                       (op != OP_WRITE && op != OP_SET && wr_data_in[4]));

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_prio0_write;
        wr_strobe_in && addr_in == PRIO0_ADDR;
    endsequence

    a_flag_on_event: assert property (
        raise[4] |=> flags[4]) else $error("flag 4 not set by event");
    a_flag_no_enable: assert property (
        raise[4] && !enables[4] |=> flags[4]) else $error("flag 4 not set while disabled");
    a_flag_persists: assert property (
        flags[4] && !clr4 |=> flags[4]) else $error("flag 4 dropped without clear");
    a_req_nonzero: assert property (
        req_valid_out |-> req_priority_out != 3'h0) else $error("request at priority 0");
    a_sub_matches: assert property (
        win_valid |=> req_subpriority_out == $past(slot_subpriority[win_idx]))
        else $error("subpriority mismatch");
    a_slot3_field: assert property (
        (s_prio0_write and (op == OP_WRITE)) |=>
        slot_priority_level[3] == $past(wr_data_in[28:26]) &&
        slot_subpriority[3] == $past(wr_data_in[25:24])) else $error("slot 3 field wrong");
    a_slot2_field: assert property (
        (s_prio0_write and (op == OP_WRITE)) |=>
        slot_priority_level[2] == $past(wr_data_in[20:18]) &&
        slot_subpriority[2] == $past(wr_data_in[17:16])) else $error("slot 2 field wrong");
    a_rsvd_zero: assert property (
        rd_prio_q |-> (rd_data_out & ~FIELD_MASK) == 32'h0000_0000)
        else $error("reserved bits read nonzero");
    a_last_reg: assert property (
        wr_strobe_in && addr_in == PRIO63_ADDR |=>
        slot_priority_level[255] == $past(wr_data_in[28:26])) else $error("register 63 bad");
    a_set_alias: assert property (
        wr_strobe_in && addr_in == FSET_ADDR && wr_data_in[5] |=> flags[5])
        else $error("set alias failed");
    a_reset_prio: assert property (
        $fell(sys_rst_in) |-> slot_priority_level[0] == 3'h0 && slot_subpriority[255] == 2'h0)
        else $error("priority not reset");
    a_winner_ok: assert property (
        win_valid |-> flags[win_idx] && enables[win_idx] ##1
        req_valid_out && req_source_out == $past(win_idx)) else $error("bad winner");

    // ------------------------------------------------------------
    // checks on aliases, holds and the interrupt status
    // ------------------------------------------------------------
    // whole-word holds catch a stray write anywhere in a word, not only in one bit
    localparam logic [ADDR_W-1:0] FCLR_ADDR   = {FLAG_IDX, 4'h4};
    localparam logic [ADDR_W-1:0] ESET_ADDR   = {ENABLE_IDX, 4'h8};
    localparam logic [ADDR_W-1:0] PINV63_ADDR = {PRIO_IDX + 8'd63, 4'hC};

    // the event bit is left out: a set in the clearing cycle wins
    sequence s_flag5_clear;
        wr_strobe_in && addr_in == FCLR_ADDR && wr_data_in[5] && !raise[5];
    endsequence

    sequence s_prio63_invert;
        wr_strobe_in && addr_in == PINV63_ADDR;
    endsequence

    sequence s_status_clear;
        st_clr && !new_flag;
    endsequence

    a_prio_slot0: assert property (
        s_prio0_write |=> slot_priority_level[0] == $past(wr_data_in[4:2]))
        else $error("slot 0 priority wrong");
    a_sub_slot0: assert property (
        s_prio0_write |=> slot_subpriority[0] == $past(wr_data_in[1:0]))
        else $error("slot 0 subpriority wrong");
    a_slot1_field: assert property (
        s_prio0_write |=> slot_priority_level[1] == $past(wr_data_in[12:10]) &&
        slot_subpriority[1] == $past(wr_data_in[9:8])) else $error("slot 1 field wrong");
    a_flag_sw_drop: assert property (
        |($past(flags) & ~flags) |-> $past(wr_strobe_in) && $past(flag_hit))
        else $error("flag dropped without a flag write");
    a_flag_rise_src: assert property (
        |(flags & ~$past(flags)) |->
        $past(|raise) || ($past(wr_strobe_in) && $past(flag_hit)))
        else $error("flag set without event or flag write");
    a_en_hold: assert property (
        !(wr_strobe_in && en_hit) |=> enables == $past(enables))
        else $error("enable changed without an enable write");
    a_prio_hold: assert property (
        !(wr_strobe_in && prio_hit && prio_off == 8'h00) |=>
        prio_word[0] == $past(prio_word[0]))
        else $error("priority register 0 changed without a write");
    a_clr_alias: assert property (
        s_flag5_clear |=> !flags[5]) else $error("clear alias failed");
    a_en_set: assert property (
        wr_strobe_in && addr_in == ESET_ADDR && wr_data_in[4] |=> enables[4])
        else $error("enable set alias failed");
    a_inv_alias: assert property (
        s_prio63_invert |=>
        prio_word[63] == ($past(prio_word[63] ^ wr_data_in) & FIELD_MASK))
        else $error("invert alias failed");
    a_req_idle: assert property (
        !win_valid |=> !req_valid_out) else $error("request without a winner");
    a_rd_idle: assert property (
        !rd_strobe_in |=> rd_data_out == 32'h0000_0000)
        else $error("read data outside its cycle");
    a_mask_write: assert property (
        wr_strobe_in && mask_hit |=> irq_mask == $past(wr_data_in[0]))
        else $error("mask write lost");
    // status is sticky: a raise of a flag not yet set, in the clearing cycle, keeps it set
    a_status_set: assert property (
        new_flag |=> irq_status) else $error("status not set by new flag");
    a_status_clear: assert property (
        s_status_clear |=> !irq_status) else $error("status not cleared");

endmodule : ipf_top

`default_nettype wire

// >>> testbench/ipf_src_model.sv
// peripheral event sources facing the flag inputs of the block
`default_nettype none

module ipf_src_model (
    // clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    // commands from the bench
    input  wire logic                        ev_stb_in,
    input  wire logic                        on_stb_in,
    input  wire logic                        on_val_in,
    input  wire logic [ipf_pkg::SRC_W-1:0]   idx_in,
    // lines into the block
    output logic      [ipf_pkg::NUM_SRC-1:0] event_out,
    output logic      [ipf_pkg::NUM_SRC-1:0] periph_en_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import ipf_pkg::*;

    // ------------------------------------------------------------
    // one-cycle event pulses and peripheral enables
    // ------------------------------------------------------------
    // events pulse even for a peripheral that is off, so the block must gate them
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            event_out     <= '0;
            periph_en_out <= '0;
        end else begin
            event_out <= '0;
            if (ev_stb_in) begin
                event_out[idx_in] <= 1'b1;
            end
            if (on_stb_in) begin
                periph_en_out[idx_in] <= on_val_in;
            end
        end
    end

endmodule : ipf_src_model

`default_nettype wire

// >>> testbench/ipf_top_tb.sv
// self-checking bench of the interrupt priority and flag block
`default_nettype none

module ipf_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ipf_pkg::*;

    logic                clk, rst, wr, rd, ev_stb, on_stb, on_val, req_valid, irq;
    logic [ADDR_W-1:0]   addr;
    logic [31:0]         wdata, rdata;
    logic [SRC_W-1:0]    idx, req_src;
    logic [NUM_SRC-1:0]  ev_vec, en_vec;
    logic [2:0]          req_prio;
    logic [1:0]          req_sub;
    int                  fails, compares;

    ipf_top dut_u (.ref_clk_in(clk), .sys_rst_in(rst), .addr_in(addr), .wr_data_in(wdata),
        .wr_strobe_in(wr), .rd_strobe_in(rd), .rd_data_out(rdata), .src_event_in(ev_vec),
        .src_periph_en_in(en_vec), .req_valid_out(req_valid), .req_source_out(req_src),
        .req_priority_out(req_prio), .req_subpriority_out(req_sub), .irq_out(irq));

    ipf_src_model src_u (.clk_in(clk), .rst_in(rst), .ev_stb_in(ev_stb), .on_stb_in(on_stb),
        .on_val_in(on_val), .idx_in(idx), .event_out(ev_vec), .periph_en_out(en_vec));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        chk(rdata, exp);
    endtask : rd_chk

    task automatic src_cmd(input logic [SRC_W-1:0] i, input logic ev, input logic on);
        @(posedge clk);
        idx    <= i;
        ev_stb <= ev;
        on_stb <= !ev;
        on_val <= on;
        @(posedge clk);
        ev_stb <= 1'b0;
        on_stb <= 1'b0;
    endtask : src_cmd

    // pulse reaches the flag on the next edge, the request one edge later
    task automatic req_chk(input logic [SRC_W-1:0] s, input logic [2:0] p, input logic [1:0] b);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({18'h0, req_valid, req_src, req_prio, req_sub}, {18'h0, 1'b1, s, p, b});
    endtask : req_chk

    task automatic give_verdict;
        if (fails == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        {rst, wr, rd, ev_stb, on_stb, on_val} = 6'b10_0000;
        {addr, wdata, idx} = '0;
        fails = 0;
        compares = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_chk(12'h100, REG_RST);
        wr_reg(12'h100, 32'h0B06_1D0E);
        rd_chk(12'h100, 32'h0B06_1D0E);
        rd_chk(12'h4F0, REG_RST);
        wr_reg(12'h4F0, 32'hFFFF_FFFF);
        rd_chk(12'h4F0, 32'h1F1F_1F1F);
        wr_reg(12'h4F4, 32'h0000_1F00);
        rd_chk(12'h4F0, 32'h1F1F_001F);
        wr_reg(12'h4F8, 32'h0000_0500);
        rd_chk(12'h4F0, 32'h1F1F_051F);
        wr_reg(12'h4FC, 32'h1C03_0000);
        rd_chk(12'h4F0, 32'h031C_051F);
        rd_chk(12'h600, 32'h0000_0000);
        src_cmd(8'h04, 1'b1, 1'b0);
        rd_chk(12'h000, 32'h0000_0000);
        src_cmd(8'h04, 1'b0, 1'b1);
        src_cmd(8'h04, 1'b1, 1'b0);
        rd_chk(12'h000, 32'h0000_0010);
        chk({31'h0, req_valid}, 32'h0000_0000);
        rd_chk(12'h500, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        wr_reg(12'h510, 32'h0000_0001);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0000_0001);
        wr_reg(12'h500, 32'h0000_0001);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        repeat (20) @(posedge clk);
        rd_chk(12'h000, 32'h0000_0010);
        src_cmd(8'h05, 1'b0, 1'b1);
        src_cmd(8'h06, 1'b0, 1'b1);
        wr_reg(12'h110, 32'h0000_0E0D);
        wr_reg(12'h088, 32'h0000_0070);
        src_cmd(8'h05, 1'b1, 1'b0);
        src_cmd(8'h06, 1'b1, 1'b0);
        req_chk(8'h05, 3'h3, 2'h2);
        wr_reg(12'h004, 32'h0000_0020);
        req_chk(8'h04, 3'h3, 2'h1);
        wr_reg(12'h008, 32'h0000_0020);
        req_chk(8'h05, 3'h3, 2'h2);
        wr_reg(12'h118, 32'h001C_0000);
        req_chk(8'h06, 3'h7, 2'h0);
        wr_reg(12'h000, 32'h0000_0000);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({31'h0, req_valid}, 32'h0000_0000);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(12'h100, REG_RST);
        rd_chk(12'h4F0, REG_RST);
        give_verdict();
    end

endmodule : ipf_top_tb

`default_nettype wire
